// file: dv/tb_tuning_dac_track_hold_control.sv
// Self-checking bench of the tuning DAC track/hold control
`timescale 1ns/100ps
`include "tdth_consts.svh"
module tb_tuning_dac_track_hold_control;
	logic                 aclk, aresetn, awvalid, wvalid, bready;
	logic                 arvalid, rready, awready, wready, bvalid;
	logic                 arready, rvalid, fh, ch, fw, cw, fc, cc;
	logic [11:0]          awaddr, araddr, ft, ct, cur, trial;
	logic [31:0]          wdata, rdata;
	logic [1:0]           bresp, rresp;
	logic [7:0]           r;
	tdth_pkg::tdth_code_t fcode, ccode;
	logic [47:0]          q[$];
	int                   error_cnt, n_tests, seed, i, k;

	// Design, with one comparator model per side
	tdth_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fine_cmp_above(fc), .crs_cmp_above(cc),
		.fine_dac_code(fcode), .crs_dac_code(ccode), .fine_hold(fh),
		.crs_hold(ch), .fine_wb_en(fw), .crs_wb_en(cw));
	tdth_side_model fine_side (.dac_code(fcode), .target(ft), .cmp_above(fc));
	tdth_side_model crs_side (.dac_code(ccode), .target(ct), .cmp_above(cc));

	// Clock of 100 ns period
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task chk(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			error_cnt++;
		end
	endtask

	task give_verdict;
		$display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Write: address and data offered together, each released when taken
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		q.push_back({14'h0, e, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		q.push_back({14'h0, e, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	task ld(input logic [7:0] s, input logic [7:0] d);
		wr(`TDTH_ADDR_STEER, {24'h0, s}, `TDTH_RESP_OKAY);
		wr(`TDTH_ADDR_DATA, {24'h0, d}, `TDTH_RESP_OKAY);
	endtask

	// Low twelve fine bits through mid-only then low-only steering, in hold
	task load12(input logic [11:0] v);
		ld(8'h7d, {4'h0, v[11:8]});
		ld(8'h7e, v[7:0]);
	endtask

	// Response watcher: oldest note against each answer
	always @(posedge aclk)
	begin
		if (bvalid && bready)
			chk({14'h0, bresp, 32'h0}, q.pop_front());
		if (rvalid && rready)
			chk({14'h0, rresp, rdata}, q.pop_front());
	end

	// Watchdog
	initial
	begin
		#3000000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		seed = 95228;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, ft, cur} = 80'h0;
		ct = 12'h059;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`TDTH_ADDR_STATUS, 32'h77, `TDTH_RESP_OKAY);
		chk({ccode, fcode}, 48'h0);
		ld(8'h00, 8'h5a);
		ld(8'h00, 8'h00);
		chk({ccode, fcode}, 48'h0);
		@(posedge aclk);
		chk({46'h0, fh, ch}, 48'h3);
		repeat (12) @(posedge aclk);
		chk({46'h0, fh, ch}, 48'h0);
		ld(8'h00, 8'hff);
		chk({ccode, fcode}, 48'hffffff_ffffff);
		ld(8'h00, 8'h00);
		ld(8'h33, 8'h80);
		chk({ccode, fcode}, 48'h800000_800000);
		$display("test full and mid range done");
		for (i = 0; i < 7; i++)
		begin
			r = 8'($random(seed));
			ld(8'h00, 8'h00);
			if (i != 3)
			begin
				ld(8'h77 & ~(8'h1 << i), r);
				chk({ccode, fcode},
					{40'h0, r} << (8 * (i > 3 ? i - 1 : i)));
			end
		end
		for (k = 1; k < 4; k++)
		begin
			wr(`TDTH_ADDR_STEER, {24'h0, k[1], 3'h0, k[0], 3'h0}, 2'h0);
			repeat (10) @(posedge aclk);
			chk({46'h0, ch, fh}, {46'h0, k[1:0]});
		end
		$display("test latch enables and hold done");
		ft = 12'($random(seed));
		ld(8'h7b, 8'h01);
		load12(12'h0);
		for (k = 11; k >= 0; k--)
		begin
			trial = cur | (12'h1 << k);
			load12(trial);
			wr(`TDTH_ADDR_WBACK, 32'h1, `TDTH_RESP_OKAY);
			repeat (3) @(posedge aclk);
			rd(`TDTH_ADDR_WBACK, {31'h0, trial > ft}, 2'h0);
			if (!(trial > ft))
				cur = trial;
			chk({47'h0, fh}, 48'h1);
		end
		load12(cur);
		chk({24'h0, fcode}, {24'h0, 12'h010, ft});
		wr(`TDTH_ADDR_WBACK, 32'h0, `TDTH_RESP_OKAY);
		repeat (3) @(posedge aclk);
		rd(`TDTH_ADDR_WBACK, 32'h0, `TDTH_RESP_OKAY);
		wr(`TDTH_ADDR_STEER, 32'h77, `TDTH_RESP_OKAY);
		repeat (12) @(posedge aclk);
		chk({46'h0, fh, ch}, 48'h0);
		$display("test carry approximation done");
		rd(12'h100, 32'h0, `TDTH_RESP_SLVERR);
		wr(`TDTH_ADDR_STATUS, 32'h0, `TDTH_RESP_SLVERR);
		rd(`TDTH_ADDR_STEER, 32'h0, `TDTH_RESP_SLVERR);
		$display("test bus errors done");
		ld(8'he7, 8'h5a);
		wr(`TDTH_ADDR_WBACK, 32'h2, `TDTH_RESP_OKAY);
		repeat (3) @(posedge aclk);
		rd(`TDTH_ADDR_STATUS, 32'hae7, `TDTH_RESP_OKAY);
		chk({44'h0, ch, fh, cw, fw}, 48'ha);
		$display("test coarse write-back done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`TDTH_ADDR_STATUS, 32'h77, `TDTH_RESP_OKAY);
		chk({ccode, fcode}, 48'h0);
		chk({44'h0, ch, fh, cw, fw}, 48'h0);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule // tb_tuning_dac_track_hold_control

// file: dv/tdth_side_model.sv
// Preamplifier and comparator model of one tuning side
`timescale 1ns/100ps
module tdth_side_model (
	input  wire logic [23:0] dac_code,  // Latch bytes from the design
	input  wire logic [11:0] target,    // Low code that nulls the preamp
	output logic             cmp_above  // Preamp output above local ground
);
	// Preamp swings above ground once the low code overshoots the null
	assign cmp_above = dac_code[11:0] > target;
endmodule // tdth_side_model

// file: pkg/tdth_consts.svh
// Offsets, field positions, reset values and timing counts of the tuning control
`ifndef TDTH_CONSTS_SVH
`define TDTH_CONSTS_SVH
`define TDTH_AXI_AW         12
`define TDTH_IDX_STEER      12'h070
`define TDTH_IDX_DATA       12'h071
`define TDTH_IDX_WBACK      12'h080
`define TDTH_IDX_STATUS     12'h081
`define TDTH_ADDR_STEER     12'h1c0
`define TDTH_ADDR_DATA      12'h1c4
`define TDTH_ADDR_WBACK     12'h200
`define TDTH_ADDR_STATUS    12'h204
`define TDTH_STEER_RESET    8'h77
`define TDTH_BIT_FINE_LOW   0
`define TDTH_BIT_FINE_MID   1
`define TDTH_BIT_FINE_HIGH  2
`define TDTH_BIT_FINE_HOLD  3
`define TDTH_BIT_CRS_LOW    4
`define TDTH_BIT_CRS_MID    5
`define TDTH_BIT_CRS_HIGH   6
`define TDTH_BIT_CRS_HOLD   7
`define TDTH_RESP_OKAY      2'h0
`define TDTH_RESP_SLVERR    2'h2
`define TDTH_CLK_NS         100
`define TDTH_SETTLE_NS      1000
`define TDTH_SETTLE_CYC \
	((`TDTH_SETTLE_NS + `TDTH_CLK_NS - 1) / `TDTH_CLK_NS)
`endif

// file: pkg/tdth_pkg.sv
// Types of the tuning DAC track/hold control
package tdth_pkg;
	typedef logic [7:0]  tdth_byte_t;
	typedef logic [23:0] tdth_code_t;
	typedef logic [3:0]  tdth_cnt_t;
endpackage

// file: verilog/tdth_ctrl.sv
// Tuning DAC steering, latches, track/hold and write-back control
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tdth_consts.svh"

// Function
// - Steering bits 0,1,2 enable fine low, middle, high latches
// - Steering bits 4,5,6 enable coarse low, middle, high latches
// - Bit 3 holds fine side, bit 7 holds coarse side; zero tracks
// - Latch enables are active low; 33 enables only high latches, track
// - Data write loads enabled latches; all zeros is positive full range
// - All latches enabled and FF loaded gives negative full range
// - Storage gate opens (hold) whenever a DAC is being reloaded
// - Carried side stays in hold for the whole carry interval
// - Comparator reports preamp output above or below local ground
// - Steering byte written at 70, data bytes at 71
// - Write-back comparator enable controlled by accesses to 80
module tdth_ctrl (
	input  wire logic                     aclk,           // 10 MHz clock
	input  wire logic                     aresetn,        // Sync reset, low
	input  wire logic [`TDTH_AXI_AW-1:0]  s_axi_awaddr,   // Write address
	input  wire logic                     s_axi_awvalid,  // Write addr valid
	output logic                          s_axi_awready,  // Write addr ready
	input  wire logic [31:0]              s_axi_wdata,    // Write data
	input  wire logic [3:0]               s_axi_wstrb,    // Byte enables
	input  wire logic                     s_axi_wvalid,   // Write data valid
	output logic                          s_axi_wready,   // Write data ready
	output logic [1:0]                    s_axi_bresp,    // Write response
	output logic                          s_axi_bvalid,   // Response valid
	input  wire logic                     s_axi_bready,   // Response ready
	input  wire logic [`TDTH_AXI_AW-1:0]  s_axi_araddr,   // Read address
	input  wire logic                     s_axi_arvalid,  // Read addr valid
	output logic                          s_axi_arready,  // Read addr ready
	output logic [31:0]                   s_axi_rdata,    // Read data
	output logic [1:0]                    s_axi_rresp,    // Read response
	output logic                          s_axi_rvalid,   // Read data valid
	input  wire logic                     s_axi_rready,   // Read data ready
	input  wire logic                     fine_cmp_above, // Fine preamp above gnd
	input  wire logic                     crs_cmp_above,  // Coarse preamp above
	output tdth_pkg::tdth_code_t          fine_dac_code,  // Fine {high,mid,low}
	output tdth_pkg::tdth_code_t          crs_dac_code,   // Coarse {high,mid,low}
	output logic                          fine_hold,      // Fine gate open
	output logic                          crs_hold,       // Coarse gate open
	output logic                          fine_wb_en,     // Fine comparator on
	output logic                          crs_wb_en       // Coarse comparator on
);

	localparam tdth_pkg::tdth_cnt_t SETTLE =
		tdth_pkg::tdth_cnt_t'(`TDTH_SETTLE_CYC);

	tdth_pkg::tdth_byte_t       steer;
	logic [`TDTH_AXI_AW-1:0]    awaddr_q;
	logic [31:0]                wdata_q;
	logic                       aw_held;
	logic                       w_held;
	logic                       wr_do;
	logic                       wr_steer;
	logic                       wr_data;
	logic                       wr_wback;
	logic                       fine_touch;
	logic                       crs_touch;
	tdth_pkg::tdth_cnt_t        fine_cnt;
	tdth_pkg::tdth_cnt_t        crs_cnt;
	logic [1:0]                 cmp_q;
	logic                       rd_hit;
	logic [31:0]                next_rdata;

	// Write decode once both are held; strobes ignored, low byte used
	assign wr_do    = aw_held && w_held && !s_axi_bvalid;
	assign wr_steer = wr_do && (awaddr_q == `TDTH_ADDR_STEER);
	assign wr_data  = wr_do && (awaddr_q == `TDTH_ADDR_DATA);
	assign wr_wback = wr_do && (awaddr_q == `TDTH_ADDR_WBACK);
	// A side is touched when any of its latches is enabled (low)
	assign fine_touch = wr_data && (steer[2:0] != 3'h7);
	assign crs_touch  = wr_data && (steer[6:4] != 3'h7);

	// Address and data channels accepted independently
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q      <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q      <= s_axi_wdata;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Write response; unmapped or read-only offsets answer SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TDTH_RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_steer || wr_data || wr_wback) ?
				`TDTH_RESP_OKAY : `TDTH_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Steering register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			steer <= `TDTH_STEER_RESET;
		else if (wr_steer)
			steer <= wdata_q[7:0];
	end

	// Byte latches: an enable bit at zero loads that latch
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fine_dac_code <= '0;
			crs_dac_code  <= '0;
		end
		else if (wr_data)
		begin
			for (int k = 0; k < 3; k++)
			begin
				if (!steer[`TDTH_BIT_FINE_LOW + k])
					fine_dac_code[k*8 +: 8] <= wdata_q[7:0];
				if (!steer[`TDTH_BIT_CRS_LOW + k])
					crs_dac_code[k*8 +: 8] <= wdata_q[7:0];
			end
		end
	end

	// Settle timers keep a reloaded side in hold
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fine_cnt <= '0;
			crs_cnt  <= '0;
		end
		else
		begin
			fine_cnt <= fine_touch ? SETTLE :
				(fine_cnt != '0) ? fine_cnt - 4'h1 : fine_cnt;
			crs_cnt  <= crs_touch ? SETTLE :
				(crs_cnt != '0) ? crs_cnt - 4'h1 : crs_cnt;
		end
	end

	// Storage gate drive: hold bit or reload settling
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fine_hold <= 1'b0;
			crs_hold  <= 1'b0;
		end
		else
		begin
			fine_hold <= steer[`TDTH_BIT_FINE_HOLD] || fine_touch ||
				(fine_cnt > 4'h1);
			crs_hold  <= steer[`TDTH_BIT_CRS_HOLD] || crs_touch ||
				(crs_cnt > 4'h1);
		end
	end

	// Write-back enables and gated comparator results
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fine_wb_en <= 1'b0;
			crs_wb_en  <= 1'b0;
			cmp_q      <= 2'h0;
		end
		else
		begin
			if (wr_wback)
			begin
				fine_wb_en <= wdata_q[0];
				crs_wb_en  <= wdata_q[1];
			end
			cmp_q <= {crs_cmp_above && crs_wb_en,
				fine_cmp_above && fine_wb_en};
		end
	end

	// Read mux
	always_comb
	begin
		rd_hit     = 1'b1;
		next_rdata = '0;
		case (s_axi_araddr)
			`TDTH_ADDR_WBACK:
				next_rdata = {30'h0, cmp_q};
			`TDTH_ADDR_STATUS:
				next_rdata = {20'h0, cmp_q, crs_wb_en, fine_wb_en,
					steer};
			default:
				rd_hit = 1'b0;
		endcase
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `TDTH_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= rd_hit ? `TDTH_RESP_OKAY : `TDTH_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_fine_low_load: assert property (wr_data && !steer[0] |=>
		fine_dac_code[7:0] == $past(wdata_q[7:0]))
		else $error("Fine low latch not loaded");
	a_crs_high_load: assert property (wr_data && !steer[6] |=>
		crs_dac_code[23:16] == $past(wdata_q[7:0]))
		else $error("Coarse high latch not loaded");
	a_hold_follows: assert property (steer[3] ##1 steer[3] |->
		fine_hold && (crs_hold || !$past(steer[7])))
		else $error("Hold output does not follow steering");
	a_disabled_keep: assert property (wr_data && steer[4] |=>
		$stable(crs_dac_code[7:0]))
		else $error("Disabled latch changed");
	a_reload_hold: assert property (fine_touch |=>
		fine_hold [*8])
		else $error("Fine side left hold while settling");
	a_steer_store: assert property (wr_steer |=>
		steer == $past(wdata_q[7:0]))
		else $error("Steering byte not stored");
	a_wback_enable: assert property (wr_wback |=>
		fine_wb_en == $past(wdata_q[0]) && crs_wb_en == $past(wdata_q[1]))
		else $error("Write-back enable not updated");
	a_cmp_gated: assert property (!fine_wb_en |=> !cmp_q[0])
		else $error("Comparator result visible while disabled");
	a_cmp_report: assert property (fine_wb_en && fine_cmp_above |=>
		cmp_q[0])
		else $error("Comparator result lost");
	a_write_answer: assert property (aw_held && w_held && !s_axi_bvalid
		|=> s_axi_bvalid)
		else $error("Write response missing");

	c_mid_range: cover property (wr_steer && wdata_q[7:0] == 8'h33
		##[1:20] wr_data && wdata_q[7:0] == 8'h80);
	c_carry_hold: cover property (steer[7] && crs_touch ##[1:40] wr_wback);
	c_cmp_read: cover property (s_axi_rvalid && s_axi_rdata[0]);

endmodule // tdth_ctrl
